// ### src/ftid_regs.vh
// Constants for the fourteen-bit instruction decoder core.
`ifndef FTID_REGS_VH
`define FTID_REGS_VH
`define FTID_OSC_PER_CYCLE 4
`define FTID_TOP_BYTE 2'h0
`define FTID_TOP_BIT 2'h1
`define FTID_TOP_CTRL 2'h2
`define FTID_TOP_LIT 2'h3
`define FTID_OP_MISC 4'h0
`define FTID_OP_CLEAR 4'h1
`define FTID_OP_SUB 4'h2
`define FTID_OP_DEC 4'h3
`define FTID_OP_OR 4'h4
`define FTID_OP_AND 4'h5
`define FTID_OP_XOR 4'h6
`define FTID_OP_ADD 4'h7
`define FTID_OP_MOVE 4'h8
`define FTID_OP_COM 4'h9
`define FTID_OP_INC 4'ha
`define FTID_OP_DECSZ 4'hb
`define FTID_OP_RRC 4'hc
`define FTID_OP_RLC 4'hd
`define FTID_OP_SWAP 4'he
`define FTID_OP_INCSZ 4'hf
`define FTID_BIT_CLR 2'h0
`define FTID_BIT_SET 2'h1
`define FTID_BIT_TSTC 2'h2
`define FTID_BIT_TSTS 2'h3
`define FTID_LIT_OR 4'h8
`define FTID_LIT_AND 4'h9
`define FTID_LIT_XOR 4'ha
`define FTID_W_RETURN 7'h08
`define FTID_W_RETINT 7'h09
`define FTID_W_SLEEP 7'h63
`define FTID_W_KICK 7'h64
`define FTID_NOP_WORD 14'h0000
`define FTID_ALU_ADD 4'h0
`define FTID_ALU_SUB 4'h1
`define FTID_ALU_AND 4'h2
`define FTID_ALU_OR 4'h3
`define FTID_ALU_XOR 4'h4
`define FTID_ALU_INC 4'h5
`define FTID_ALU_DEC 4'h6
`define FTID_ALU_COM 4'h7
`define FTID_ALU_PASS 4'h8
`define FTID_ALU_ACC 4'h9
`define FTID_ALU_CLR 4'ha
`define FTID_ALU_SWAP 4'hb
`define FTID_ALU_RLC 4'hc
`define FTID_ALU_RRC 4'hd
`define FTID_ALU_BCLR 4'he
`define FTID_ALU_BSET 4'hf
`define FTID_RST_ACC 8'h00
`define FTID_RST_TO 1'b1
`define FTID_RST_PD 1'b1
`endif

// ### src/ftid_alu.v
// Combinational arithmetic and logic unit of the decoder core.
`timescale 1ns/1ps
`include "ftid_regs.vh"
module ftid_alu (
  input wire [3:0] alu_op,
  input wire [7:0] acc_in,
  input wire [7:0] opnd_in,
  input wire [2:0] bit_sel,
  input wire carry_in,
  output reg [7:0] result,
  output reg carry_out,
  output reg nibble_out,
  output wire zero_out
);
  function [4:0] add_nib;
    input [3:0] a;
    input [3:0] b;
    input cin;
    begin
      add_nib = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    end
  endfunction

  function [8:0] add_byte;
    input [7:0] a;
    input [7:0] b;
    input cin;
    begin
      add_byte = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    end
  endfunction

  reg [8:0] sum;
  reg [4:0] nib;

  always @* begin
    sum = 9'h000;
    nib = 5'h00;
    result = opnd_in;
    carry_out = carry_in;
    nibble_out = 1'b0;
    case (alu_op)
      `FTID_ALU_ADD: begin
        sum = add_byte(acc_in, opnd_in, 1'b0);
        nib = add_nib(acc_in[3:0], opnd_in[3:0], 1'b0);
      end
      // Borrow shows as a cleared carry, as two's complement addition gives.
      `FTID_ALU_SUB: begin
        sum = add_byte(opnd_in, ~acc_in, 1'b1);
        nib = add_nib(opnd_in[3:0], ~acc_in[3:0], 1'b1);
      end
      `FTID_ALU_AND: result = acc_in & opnd_in;
      `FTID_ALU_OR: result = acc_in | opnd_in;
      `FTID_ALU_XOR: result = acc_in ^ opnd_in;
      `FTID_ALU_INC: result = opnd_in + 8'h01;
      `FTID_ALU_DEC: result = opnd_in - 8'h01;
      `FTID_ALU_COM: result = ~opnd_in;
      `FTID_ALU_PASS: result = opnd_in;
      `FTID_ALU_ACC: result = acc_in;
      `FTID_ALU_CLR: result = 8'h00;
      `FTID_ALU_SWAP: result = {opnd_in[3:0], opnd_in[7:4]};
      `FTID_ALU_RLC: begin
        result = {opnd_in[6:0], carry_in};
        carry_out = opnd_in[7];
      end
      `FTID_ALU_RRC: begin
        result = {carry_in, opnd_in[7:1]};
        carry_out = opnd_in[0];
      end
      `FTID_ALU_BCLR: result = opnd_in & ~(8'h01 << bit_sel);
      `FTID_ALU_BSET: result = opnd_in | (8'h01 << bit_sel);
      default: result = opnd_in;
    endcase
    if (alu_op == `FTID_ALU_ADD || alu_op == `FTID_ALU_SUB) begin
      result = sum[7:0];
      carry_out = sum[8];
      nibble_out = nib[4];
    end
  end

  assign zero_out = (result == 8'h00);
endmodule

// ### src/ftid_core.v
// Fourteen-bit instruction decoder and executor with four-phase cycle.
// Functional notes
// (RULE1) File instructions always read before writing back.
// (RULE2) Destination bit picks accumulator or file.
// (RULE3) Byte format: 00, opcode, dest, address.
// (RULE4) Add and subtract update carry, nibble, zero.
// (RULE5) AND, OR, XOR with file update zero.
// (RULE6) Increment/decrement skip on zero, no flags.
// (RULE7) Rotates through carry touch only carry.
// (RULE8) Don't-care bits never alter decoding.
// (RULE9) Bit format; clear and set bit.
// (RULE10) Bit tests skip next on clear/set.
// (RULE11) Top 10: call or jump, two cycles.
// (RULE12) Literal OR, AND, XOR update zero.
// (RULE13) Literal add and subtract update carry flags.
// (RULE14) Load literal; return with literal, two cycles.
// (RULE15) Standby and watchdog kick set status bits.
// (RULE16) Inc, dec, complement, move update zero; swap.
// (RULE17) Clear file or accumulator; store accumulator.
// (RULE18) Subroutine and interrupt returns take two cycles.
// (RULE19) Cycle is four clocks; flushes add one.
// (RULE20) Any wake from standby clears watchdog.
`timescale 1ns/1ps
`include "ftid_regs.vh"
module ftid_core (
  input wire clk,
  input wire rst_b,
  input wire [13:0] instr_word,
  input wire [7:0] file_rdata,
  input wire wake_pin,
  input wire wdt_expire,
  output reg instr_fetch,
  output reg [6:0] file_addr,
  output reg file_rd_en,
  output reg file_wr_en,
  output reg [7:0] file_wdata,
  output reg [7:0] acc_value,
  output reg carry_flag,
  output reg nibble_overflow_bit,
  output reg zero_flag,
  output reg watchdog_expired_bit,
  output reg powerdown_bit,
  output reg pc_load,
  output reg [10:0] pc_target,
  output reg stack_push,
  output reg stack_pop,
  output reg int_return,
  output reg wdt_clear,
  output reg standby
);
  // (RULE19) Four clocks per cycle
  localparam [3:0] PH_Q1 = 4'b0001;
  localparam [3:0] PH_Q2 = 4'b0010;
  localparam [3:0] PH_Q3 = 4'b0100;
  localparam [3:0] PH_Q4 = 4'b1000;

  reg [3:0] phase_reg;
  reg [3:0] phase_next;
  reg [13:0] ir_reg;
  reg [7:0] opnd_reg;
  reg flush_reg;
  reg wake_meta_reg;
  reg wake_mid_reg;
  reg wake_late_reg;
  reg wake_level_reg;

  reg [3:0] alu_op;
  reg use_file;
  reg dest_file;
  reg dest_acc;
  reg upd_c;
  reg upd_dc;
  reg upd_z;
  reg skip_zero;
  reg skip_clr;
  reg skip_set;
  reg is_call;
  reg is_jump;
  reg is_ret;
  reg is_retint;
  reg is_retlit;
  reg is_sleep;
  reg is_kick;

  wire [7:0] alu_result;
  wire alu_carry;
  wire alu_nibble;
  wire alu_zero;
  wire tested_bit;
  wire do_skip;
  wire wake_now;

  ftid_alu u_alu (
    .alu_op(alu_op),
    .acc_in(acc_value),
    .opnd_in(opnd_reg),
    .bit_sel(ir_reg[9:7]),
    .carry_in(carry_flag),
    .result(alu_result),
    .carry_out(alu_carry),
    .nibble_out(alu_nibble),
    .zero_out(alu_zero)
  );

  assign tested_bit = opnd_reg[ir_reg[9:7]];
  // (RULE6) Skip on zero result
  assign do_skip = (skip_zero & alu_zero) | (skip_clr & ~tested_bit) | (skip_set & tested_bit);
  assign wake_now = standby & (wake_level_reg | wdt_expire);

  always @* begin
    alu_op = `FTID_ALU_PASS;
    use_file = 1'b0;
    dest_file = 1'b0;
    dest_acc = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    skip_zero = 1'b0;
    skip_clr = 1'b0;
    skip_set = 1'b0;
    is_call = 1'b0;
    is_jump = 1'b0;
    is_ret = 1'b0;
    is_retint = 1'b0;
    is_retlit = 1'b0;
    is_sleep = 1'b0;
    is_kick = 1'b0;
    case (ir_reg[13:12])
      // (RULE3) Byte-oriented format
      `FTID_TOP_BYTE: begin
        if (ir_reg[11:8] == `FTID_OP_MISC) begin
          if (ir_reg[7]) begin
            // (RULE17) Store accumulator
            use_file = 1'b1;
            dest_file = 1'b1;
            alu_op = `FTID_ALU_ACC;
          end else begin
            // (RULE18) Return words
            is_ret = (ir_reg[6:0] == `FTID_W_RETURN) | (ir_reg[6:0] == `FTID_W_RETINT);
            is_retint = (ir_reg[6:0] == `FTID_W_RETINT);
            // (RULE15) Standby and kick words
            is_sleep = (ir_reg[6:0] == `FTID_W_SLEEP);
            is_kick = (ir_reg[6:0] == `FTID_W_KICK);
          end
        end else if (ir_reg[11:8] == `FTID_OP_CLEAR) begin
          // (RULE17) Clear file or accumulator
          // (RULE8) Low bits ignored for the accumulator form
          alu_op = `FTID_ALU_CLR;
          use_file = ir_reg[7];
          dest_file = ir_reg[7];
          dest_acc = ~ir_reg[7];
          upd_z = 1'b1;
        end else begin
          // (RULE1) Every file operand is read first
          use_file = 1'b1;
          // (RULE2) Destination select
          dest_file = ir_reg[7];
          dest_acc = ~ir_reg[7];
          case (ir_reg[11:8])
            // (RULE4) Add and subtract with file
            `FTID_OP_ADD: begin
              alu_op = `FTID_ALU_ADD;
              upd_c = 1'b1;
              upd_dc = 1'b1;
              upd_z = 1'b1;
            end
            `FTID_OP_SUB: begin
              alu_op = `FTID_ALU_SUB;
              upd_c = 1'b1;
              upd_dc = 1'b1;
              upd_z = 1'b1;
            end
            // (RULE5) Logic with file
            `FTID_OP_AND: begin
              alu_op = `FTID_ALU_AND;
              upd_z = 1'b1;
            end
            `FTID_OP_OR: begin
              alu_op = `FTID_ALU_OR;
              upd_z = 1'b1;
            end
            `FTID_OP_XOR: begin
              alu_op = `FTID_ALU_XOR;
              upd_z = 1'b1;
            end
            // (RULE6) Counting skips
            `FTID_OP_INCSZ: begin
              alu_op = `FTID_ALU_INC;
              skip_zero = 1'b1;
            end
            `FTID_OP_DECSZ: begin
              alu_op = `FTID_ALU_DEC;
              skip_zero = 1'b1;
            end
            // (RULE7) Rotates through carry
            `FTID_OP_RLC: begin
              alu_op = `FTID_ALU_RLC;
              upd_c = 1'b1;
            end
            `FTID_OP_RRC: begin
              alu_op = `FTID_ALU_RRC;
              upd_c = 1'b1;
            end
            // (RULE16) Single-operand file ops
            `FTID_OP_INC: begin
              alu_op = `FTID_ALU_INC;
              upd_z = 1'b1;
            end
            `FTID_OP_DEC: begin
              alu_op = `FTID_ALU_DEC;
              upd_z = 1'b1;
            end
            `FTID_OP_COM: begin
              alu_op = `FTID_ALU_COM;
              upd_z = 1'b1;
            end
            `FTID_OP_MOVE: begin
              alu_op = `FTID_ALU_PASS;
              upd_z = 1'b1;
            end
            `FTID_OP_SWAP: alu_op = `FTID_ALU_SWAP;
            default: alu_op = `FTID_ALU_PASS;
          endcase
        end
      end
      // (RULE9) Bit-oriented format
      `FTID_TOP_BIT: begin
        use_file = 1'b1;
        case (ir_reg[11:10])
          `FTID_BIT_CLR: begin
            alu_op = `FTID_ALU_BCLR;
            dest_file = 1'b1;
          end
          `FTID_BIT_SET: begin
            alu_op = `FTID_ALU_BSET;
            dest_file = 1'b1;
          end
          // (RULE10) Bit test skips
          `FTID_BIT_TSTC: skip_clr = 1'b1;
          default: skip_set = 1'b1;
        endcase
      end
      // (RULE11) Call or jump
      `FTID_TOP_CTRL: begin
        is_call = ~ir_reg[11];
        is_jump = ir_reg[11];
      end
      default: begin
        // (RULE8) Literal sub-codes ignore their x bit
        casez (ir_reg[11:8])
          // (RULE14) Load and return literal
          4'b00??: begin
            alu_op = `FTID_ALU_PASS;
            dest_acc = 1'b1;
          end
          4'b01??: begin
            alu_op = `FTID_ALU_PASS;
            dest_acc = 1'b1;
            is_retlit = 1'b1;
          end
          // (RULE12) Literal logic
          `FTID_LIT_OR: begin
            alu_op = `FTID_ALU_OR;
            dest_acc = 1'b1;
            upd_z = 1'b1;
          end
          `FTID_LIT_AND: begin
            alu_op = `FTID_ALU_AND;
            dest_acc = 1'b1;
            upd_z = 1'b1;
          end
          `FTID_LIT_XOR: begin
            alu_op = `FTID_ALU_XOR;
            dest_acc = 1'b1;
            upd_z = 1'b1;
          end
          // (RULE13) Literal add and subtract
          4'b110?: begin
            alu_op = `FTID_ALU_SUB;
            dest_acc = 1'b1;
            upd_c = 1'b1;
            upd_dc = 1'b1;
            upd_z = 1'b1;
          end
          4'b111?: begin
            alu_op = `FTID_ALU_ADD;
            dest_acc = 1'b1;
            upd_c = 1'b1;
            upd_dc = 1'b1;
            upd_z = 1'b1;
          end
          default: alu_op = `FTID_ALU_PASS;
        endcase
      end
    endcase
  end

  // (RULE19) Phase sequencing, held in Q1 during standby
  always @* begin
    case (phase_reg)
      PH_Q1: phase_next = standby ? PH_Q1 : PH_Q2;
      PH_Q2: phase_next = PH_Q3;
      PH_Q3: phase_next = PH_Q4;
      PH_Q4: phase_next = PH_Q1;
      default: phase_next = PH_Q1;
    endcase
  end

  // The first stage only feeds the second, so metastability cannot spread.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_meta_reg <= 1'b0;
      wake_mid_reg <= 1'b0;
      wake_late_reg <= 1'b0;
      wake_level_reg <= 1'b0;
    end else begin
      wake_meta_reg <= wake_pin;
      wake_mid_reg <= wake_meta_reg;
      wake_late_reg <= wake_mid_reg;
      if (wake_mid_reg == wake_late_reg) begin
        wake_level_reg <= wake_late_reg;
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= PH_Q1;
      ir_reg <= `FTID_NOP_WORD;
      opnd_reg <= 8'h00;
      flush_reg <= 1'b0;
      instr_fetch <= 1'b0;
      file_addr <= 7'h00;
      file_rd_en <= 1'b0;
      file_wr_en <= 1'b0;
      file_wdata <= 8'h00;
      acc_value <= `FTID_RST_ACC;
      carry_flag <= 1'b0;
      nibble_overflow_bit <= 1'b0;
      zero_flag <= 1'b0;
      watchdog_expired_bit <= `FTID_RST_TO;
      powerdown_bit <= `FTID_RST_PD;
      pc_load <= 1'b0;
      pc_target <= 11'h000;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      int_return <= 1'b0;
      wdt_clear <= 1'b0;
      standby <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      instr_fetch <= 1'b0;
      file_rd_en <= 1'b0;
      file_wr_en <= 1'b0;
      pc_load <= 1'b0;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      int_return <= 1'b0;
      wdt_clear <= 1'b0;
      // (RULE20) Wake clears the watchdog
      if (wake_now) begin
        standby <= 1'b0;
        wdt_clear <= 1'b1;
        if (wdt_expire) begin
          watchdog_expired_bit <= 1'b0;
        end
      end
      case (phase_reg)
        PH_Q1: begin
          // (RULE19) A flushed slot runs as a no-operation
          if (!standby) begin
            ir_reg <= flush_reg ? `FTID_NOP_WORD : instr_word;
            flush_reg <= 1'b0;
          end
        end
        PH_Q2: begin
          // (RULE1) Read strobe for every file operand
          file_addr <= ir_reg[6:0];
          file_rd_en <= use_file;
          instr_fetch <= 1'b1;
        end
        PH_Q3: opnd_reg <= use_file ? file_rdata : ir_reg[7:0];
        PH_Q4: begin
          // (RULE2) Result steering
          if (dest_file) begin
            file_wr_en <= 1'b1;
            file_wdata <= alu_result;
          end
          if (dest_acc) begin
            acc_value <= alu_result;
          end
          if (upd_c) begin
            carry_flag <= alu_carry;
          end
          if (upd_dc) begin
            nibble_overflow_bit <= alu_nibble;
          end
          if (upd_z) begin
            zero_flag <= alu_zero;
          end
          // (RULE11) Transfers load the target and flush
          if (is_call | is_jump) begin
            pc_load <= 1'b1;
            pc_target <= ir_reg[10:0];
          end
          stack_push <= is_call;
          // (RULE18) Returns pop and flush
          stack_pop <= is_ret | is_retlit;
          int_return <= is_retint;
          if (do_skip | is_call | is_jump | is_ret | is_retlit) begin
            flush_reg <= 1'b1;
          end
          // (RULE15) Standby and kick status
          if (is_sleep | is_kick) begin
            wdt_clear <= 1'b1;
            watchdog_expired_bit <= 1'b1;
            powerdown_bit <= is_kick;
          end
          if (is_sleep) begin
            standby <= 1'b1;
          end
        end
        default: ir_reg <= ir_reg;
      endcase
    end
  end
endmodule

// ### verification/ftid_core_checker.sv
// Port-level assertions for the instruction decoder core.
`timescale 1ns/1ps
module ftid_core_checker (
  input logic clk,
  input logic rst_b,
  input logic [13:0] instr_word,
  input logic instr_fetch,
  input logic [6:0] file_addr,
  input logic file_rd_en,
  input logic file_wr_en,
  input logic pc_load,
  input logic [10:0] pc_target,
  input logic stack_push,
  input logic stack_pop,
  input logic int_return,
  input logic wdt_clear,
  input logic standby,
  input logic powerdown_bit,
  input logic watchdog_expired_bit
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // A fetch followed by three running clocks must lead to the next fetch.
  sequence s_run_on;
    instr_fetch ##1 !standby [*3];
  endsequence
  // The word taken four edges back was one of the three return forms.
  sequence s_ret_word;
    $past(instr_word, 4) == 14'h0008 || $past(instr_word, 4) == 14'h0009 || $past(instr_word[13:10], 4) == 4'hd;
  endsequence
  a_read_first: assert property (file_wr_en |-> $past(file_rd_en, 2) && $past(file_addr, 2) == file_addr)
    else $error("file write without a matching read");
  a_read_addr: assert property (file_rd_en |-> file_addr == $past(instr_word[6:0], 2))
    else $error("file address differs from the word");
  a_dest_pick: assert property (file_wr_en |-> (($past(instr_word[13:12], 4) == 2'h0) ?
    $past(instr_word[7], 4) : ($past(instr_word[13:11], 4) == 3'h2)))
    else $error("file written by a word that does not target it");
  a_fetch_gap: assert property (instr_fetch |=> !instr_fetch [*3])
    else $error("fetches closer than four clocks");
  a_cycle_four: assert property (s_run_on |=> instr_fetch)
    else $error("running core missed a fetch");
  a_jump_target: assert property (pc_load |-> $past(instr_word[13:12], 4) == 2'h2 &&
    pc_target == $past(instr_word[10:0], 4) && stack_push == !$past(instr_word[11], 4))
    else $error("wrong transfer target or push");
  a_pop_cause: assert property (stack_pop |-> s_ret_word)
    else $error("stack popped by a non-return word");
  a_int_return: assert property (int_return |-> stack_pop && $past(instr_word, 4) == 14'h0009)
    else $error("interrupt return flag without its word");
  a_standby_entry: assert property ($rose(standby) |-> !powerdown_bit && watchdog_expired_bit && wdt_clear)
    else $error("standby entered with wrong status");
  a_wake_clear: assert property ($fell(standby) |-> wdt_clear)
    else $error("wake without watchdog clear");
  a_halt_fetch: assert property (standby |-> !instr_fetch)
    else $error("fetch during standby");
  a_kick_flags: assert property (wdt_clear && !standby && !$fell(standby) |-> powerdown_bit && watchdog_expired_bit)
    else $error("watchdog kick left wrong status");
endmodule
bind ftid_core ftid_core_checker u_chk (.clk(clk), .rst_b(rst_b), .instr_word(instr_word),
  .instr_fetch(instr_fetch), .file_addr(file_addr), .file_rd_en(file_rd_en), .file_wr_en(file_wr_en),
  .pc_load(pc_load), .pc_target(pc_target), .stack_push(stack_push), .stack_pop(stack_pop),
  .int_return(int_return), .wdt_clear(wdt_clear), .standby(standby), .powerdown_bit(powerdown_bit),
  .watchdog_expired_bit(watchdog_expired_bit));

// ### verification/ftid_prog_mem.sv
// Program memory with its address counter and return stack.
`timescale 1ns/1ps
module ftid_prog_mem (
  input logic clk,
  input logic rst_b,
  input logic instr_fetch,
  input logic pc_load,
  input logic [10:0] pc_target,
  input logic stack_push,
  input logic stack_pop,
  output logic [13:0] instr_word
);
  logic [13:0] mem [0:31];
  logic [10:0] stack [0:7];
  logic [10:0] next_addr;
  logic [2:0] sp;
  // The word after a fetch stays put until the core takes it, also through standby.
  always @(posedge clk) begin
    if (!rst_b) begin
      instr_word <= mem[0];
      next_addr <= 11'h001;
      sp <= 3'h0;
    end else begin
      if (instr_fetch) begin
        instr_word <= mem[next_addr[4:0]];
        next_addr <= next_addr + 11'h001;
      end
      if (pc_load) next_addr <= pc_target;
      if (stack_push) begin
        stack[sp] <= next_addr - 11'h001;
        sp <= sp + 3'h1;
      end
      if (stack_pop) begin
        next_addr <= stack[sp - 3'h1];
        sp <= sp - 3'h1;
      end
    end
  end
endmodule

// ### verification/ftid_core_bench.sv
// Self-checking bench for the instruction decoder core.
`timescale 1ns/1ps
module ftid_core_bench;
  typedef struct packed {
    logic [13:0] op;
    logic [7:0] a;
    logic [7:0] f;
    logic [7:0] acc;
    logic wr;
    logic [7:0] wd;
    logic [2:0] flags;
  } ftid_row_t;
  logic clk, rst_b, wake_pin, wdt_expire, instr_fetch, file_rd_en, file_wr_en;
  logic carry_flag, nibble_overflow_bit, zero_flag, watchdog_expired_bit, powerdown_bit;
  logic pc_load, stack_push, stack_pop, int_return, wdt_clear, standby;
  logic [13:0] instr_word;
  logic [7:0] file_rdata, file_wdata, acc_value;
  logic [6:0] file_addr;
  logic [10:0] pc_target;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  ftid_row_t rows [23] = '{
    '{14'h07ff, 8'h0f, 8'hf1, 8'h0f, 1'h1, 8'h00, 3'h7},
    '{14'h0200, 8'h01, 8'h10, 8'h0f, 1'h0, 8'h00, 3'h4},
    '{14'h0500, 8'hf0, 8'h0f, 8'h00, 1'h0, 8'h00, 3'h1},
    '{14'h0492, 8'h30, 8'h03, 8'h30, 1'h1, 8'h33, 3'h0},
    '{14'h0600, 8'hff, 8'h0f, 8'hf0, 1'h0, 8'h00, 3'h0},
    '{14'h0a00, 8'h12, 8'hff, 8'h00, 1'h0, 8'h00, 3'h1},
    '{14'h0380, 8'h12, 8'h01, 8'h12, 1'h1, 8'h00, 3'h1},
    '{14'h0900, 8'h12, 8'h5a, 8'ha5, 1'h0, 8'h00, 3'h0},
    '{14'h0800, 8'h77, 8'h00, 8'h00, 1'h0, 8'h00, 3'h1},
    '{14'h0e00, 8'h12, 8'h3c, 8'hc3, 1'h0, 8'h00, 3'h0},
    '{14'h0d00, 8'h12, 8'h81, 8'h02, 1'h0, 8'h00, 3'h4},
    '{14'h0c80, 8'h12, 8'h01, 8'h12, 1'h1, 8'h00, 3'h4},
    '{14'h0185, 8'h44, 8'h9c, 8'h44, 1'h1, 8'h00, 3'h1},
    '{14'h017f, 8'h44, 8'h9c, 8'h00, 1'h0, 8'h00, 3'h1},
    '{14'h00a0, 8'h9c, 8'h00, 8'h9c, 1'h1, 8'h9c, 3'h0},
    '{14'h1190, 8'h12, 8'hff, 8'h12, 1'h1, 8'hf7, 3'h0},
    '{14'h1780, 8'h12, 8'h00, 8'h12, 1'h1, 8'h80, 3'h0},
    '{14'h380f, 8'hf0, 8'h00, 8'hff, 1'h0, 8'h00, 3'h0},
    '{14'h3900, 8'hff, 8'h00, 8'h00, 1'h0, 8'h00, 3'h1},
    '{14'h3aaa, 8'haa, 8'h00, 8'h00, 1'h0, 8'h00, 3'h1},
    '{14'h3d10, 8'h01, 8'h00, 8'h0f, 1'h0, 8'h00, 3'h4},
    '{14'h335a, 8'h12, 8'h00, 8'h5a, 1'h0, 8'h00, 3'h0},
    '{14'h3f01, 8'hff, 8'h00, 8'h00, 1'h0, 8'h00, 3'h7}};
  // Word under test, file operand, accumulator after the following load of 11.
  logic [29:0] skp [7] = '{{14'h0f00, 8'hff, 8'h00}, {14'h0b00, 8'h02, 8'h11}, {14'h0b80, 8'h01, 8'h00},
    {14'h1800, 8'hfe, 8'h00}, {14'h1800, 8'h01, 8'h11}, {14'h1f80, 8'h80, 8'h00}, {14'h1f80, 8'h7f, 8'h11}};
  ftid_core dut (.clk(clk), .rst_b(rst_b), .instr_word(instr_word), .file_rdata(file_rdata),
    .wake_pin(wake_pin), .wdt_expire(wdt_expire), .instr_fetch(instr_fetch), .file_addr(file_addr),
    .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .file_wdata(file_wdata), .acc_value(acc_value),
    .carry_flag(carry_flag), .nibble_overflow_bit(nibble_overflow_bit), .zero_flag(zero_flag),
    .watchdog_expired_bit(watchdog_expired_bit), .powerdown_bit(powerdown_bit), .pc_load(pc_load),
    .pc_target(pc_target), .stack_push(stack_push), .stack_pop(stack_pop), .int_return(int_return),
    .wdt_clear(wdt_clear), .standby(standby));
  ftid_prog_mem pm (.clk(clk), .rst_b(rst_b), .instr_fetch(instr_fetch), .pc_load(pc_load),
    .pc_target(pc_target), .stack_push(stack_push), .stack_pop(stack_pop), .instr_word(instr_word));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop;
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // Restarting from reset every time also exercises a reset in mid-program.
  task automatic boot(input logic [13:0] w0, input logic [13:0] w1, input logic [13:0] w2, input logic [7:0] f);
    @(posedge clk);
    rst_b <= 1'b0;
    file_rdata <= f;
    pm.mem[0] = w0;
    pm.mem[1] = w1;
    pm.mem[2] = w2;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_sb(input logic v);
    int n;
    n = 0;
    while (standby !== v && n < 40) begin
      step(1);
      n++;
    end
  endtask
  initial begin
    rst_b = 1'b0;
    wake_pin = 1'b0;
    wdt_expire = 1'b0;
    file_rdata = 8'h00;
    for (int i = 0; i < 32; i++) pm.mem[i] = 14'h0000;
    foreach (rows[i]) begin
      boot({6'h30, rows[i].a}, rows[i].op, 14'h0000, rows[i].f);
      step(8);
      chk8(acc_value, rows[i].acc);
      chk1(file_wr_en, rows[i].wr);
      if (rows[i].wr) chk8(file_wdata, rows[i].wd);
      chk8({5'h00, carry_flag, nibble_overflow_bit, zero_flag}, {5'h00, rows[i].flags});
    end
    @(posedge clk);
    rst_b <= 1'b0;
    step(1);
    chk8({acc_value[6:0], zero_flag}, 8'h00);
    chk1(watchdog_expired_bit & powerdown_bit, 1'b1);
    foreach (skp[i]) begin
      boot(skp[i][29:16], 14'h3011, 14'h0000, skp[i][15:8]);
      step(8);
      chk8(acc_value, skp[i][7:0]);
    end
    boot(14'h2004, 14'h3011, 14'h2807, 8'h00);
    pm.mem[4] = 14'h2006;
    pm.mem[5] = 14'h0008;
    pm.mem[6] = 14'h3466;
    pm.mem[7] = 14'h2008;
    pm.mem[8] = 14'h3077;
    pm.mem[9] = 14'h0009;
    step(24);
    chk8(acc_value, 8'h66);
    step(12);
    chk8(acc_value, 8'h11);
    step(28);
    chk8(acc_value, 8'h77);
    boot(14'h0064, 14'h0063, 14'h305a, 8'h00);
    pm.mem[3] = 14'h0063;
    pm.mem[4] = 14'h303c;
    pm.mem[5] = 14'h0000;
    step(12);
    chk1(standby, 1'b1);
    chk1(powerdown_bit, 1'b0);
    chk1(watchdog_expired_bit, 1'b1);
    @(posedge clk);
    wake_pin <= 1'b1;
    wait_sb(1'b0);
    chk1(wdt_clear, 1'b1);
    @(posedge clk);
    wake_pin <= 1'b0;
    wait_sb(1'b1);
    chk8(acc_value, 8'h5a);
    @(posedge clk);
    wdt_expire <= 1'b1;
    @(posedge clk);
    wdt_expire <= 1'b0;
    wait_sb(1'b0);
    chk1(watchdog_expired_bit, 1'b0);
    step(8);
    chk8(acc_value, 8'h3c);
    report_and_stop;
  end
endmodule
